// ### tb/tdm_framer_model.sv
// Behavioural framer on the line side of one TDM port.
// Assumes the bench calls send_frame and reads txSeen afterwards.
`timescale 1ns/100ps
`default_nettype none

module tdm_framer_model (
  // Line toward the port
  output logic lineClk,
  output logic lineSync,
  output logic lineData,
  // Transmit wire as seen on the line
  input wire logic txLine,
  // Line conventions
  input wire logic fallEdge,
  input wire logic syncLow
);
  logic busy = 1'h0;
  logic txSeen [0:31];

  // Park clock and sync; the clock stands still between frames
  always @(fallEdge or syncLow or busy) begin
    if (!busy) begin
      lineClk = fallEdge;
      lineSync = syncLow;
    end
  end

  initial lineData = 1'h0;

  // Sync at slot 0, data from slot dly, spare slots for late tx bits
  task automatic send_frame(input logic [31:0] bits, input int n,
                            input int dly);
    busy = 1'h1;
    for (int p = 0; p < dly + n + 3; p++) begin
      lineSync = (p == 0) ^ syncLow;
      lineData = (p >= dly && p < dly + n) ? bits[p - dly]
                 : ~lineData; // Toggles so stale bits never match
      #40 lineClk = ~fallEdge;
      txSeen[p] = txLine;
      #40 lineClk = fallEdge;
    end
    lineData = ~lineData;
    busy = 1'h0;
  endtask
endmodule // tdm_framer_model

`default_nettype wire

// ### tb/tdm_port_checker.sv
// Assertions on one TDM port: memory stream, fetches, offsets, pins.
// Assumes it is bound into tdm_port and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none

module tdm_port_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Configuration
  input wire logic txEnable,
  input wire logic txSyncIsOutput,
  input wire logic [1:0] wordSel,
  input wire logic compandOn,
  input wire logic [31:0] rxActive,
  input wire logic [31:0] txActive,
  input wire logic [21:0] bufSize,
  input wire logic [21:0] rxThresh0,
  input wire logic [21:0] txThresh0,
  // Memory and fetch sides
  input wire logic memWrValid,
  input wire logic memWrReady,
  input wire logic [4:0] memWrChan,
  input wire logic [27:0] memWrOffset,
  input wire logic [15:0] memWrData,
  input wire logic txReqValid,
  input wire logic [4:0] txReqChan,
  // Status and pins
  input wire logic [27:0] rxWriteOffset,
  input wire logic [27:0] txReadOffset,
  input wire logic [1:0] rxThreshHit,
  input wire logic [1:0] txThreshHit,
  input wire logic txFrameSyncOe,
  input wire logic txDataOe
);
  // Offset advance per frame; companded words are stored 16 bits wide
  wire [27:0] stepBits = compandOn ? 28'h10 : 28'h2 << wordSel;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // --------------------------------------------------------------
  // Offset update steps
  // --------------------------------------------------------------
  sequence rxStep_s; $changed(rxWriteOffset); endsequence
  sequence txStep_s; $changed(txReadOffset); endsequence
  sequence rxAtThr_s;
    rxStep_s ##0 rxWriteOffset == {rxThresh0, 6'h0};
  endsequence
  sequence txAtThr_s;
    txStep_s ##0 txReadOffset == {txThresh0, 6'h0};
  endsequence

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  wr_hold_a: assert property (
    memWrValid && !memWrReady |=> memWrValid &&
    $stable({memWrChan, memWrOffset, memWrData}))
    else $error("Stalled word changed");
  rx_active_a: assert property (
    memWrValid |-> rxActive[memWrChan])
    else $error("Word from inactive channel");
  tx_active_a: assert property (
    txReqValid |-> txActive[txReqChan] ##1 !txReqValid)
    else $error("Bad fetch request");
  rx_step_a: assert property (
    rxStep_s |-> rxWriteOffset == 28'h0 ||
    rxWriteOffset == $past(rxWriteOffset) + stepBits)
    else $error("Bad write offset step");
  tx_step_a: assert property (
    txStep_s |-> txReadOffset == 28'h0 ||
    txReadOffset == $past(txReadOffset) + stepBits)
    else $error("Bad read offset step");
  off_wrap_a: assert property (
    rxWriteOffset < {bufSize, 6'h0} && txReadOffset < {bufSize, 6'h0})
    else $error("Offset past buffer");
  rx_hit_a: assert property (
    rxAtThr_s |-> ##[0:1] rxThreshHit[0])
    else $error("Missing receive event");
  tx_hit_a: assert property (
    txAtThr_s |-> ##[0:1] txThreshHit[0])
    else $error("Missing transmit event");
  sync_oe_a: assert property (
    1'b1 |=> txFrameSyncOe == $past(txEnable && txSyncIsOutput))
    else $error("Sync enable wrong");
  tx_quiet_a: assert property (
    !txEnable [*2] |=> !txDataOe)
    else $error("Data driven while off");
endmodule // tdm_port_checker

bind tdm_port tdm_port_checker i_tdm_port_checker (.clk, .reset,
  .txEnable, .txSyncIsOutput, .wordSel, .compandOn, .rxActive,
  .txActive, .bufSize, .rxThresh0, .txThresh0, .memWrValid, .memWrReady,
  .memWrChan, .memWrOffset, .memWrData, .txReqValid, .txReqChan,
  .rxWriteOffset, .txReadOffset, .rxThreshHit, .txThreshHit,
  .txFrameSyncOe, .txDataOe);

`default_nettype wire

// ### tb/tdm_port_test.sv
// Self-checking bench for one TDM port with a framer on the line.
// Assumes design, checker and framer model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tdm_port_test;
  logic clk = 1'h0, reset = 1'h1, rxEnable, txEnable, sharedMode, stall;
  logic txSyncIsOutput, sampleFalling, syncActiveLow, lsbFirst, compandOn;
  logic compandALaw, memWrReady, txRspValid;
  logic [1:0] frameDelay, wordSel;
  logic [4:0] lastChan, rspChan;
  logic [31:0] rxActive, txActive;
  logic [21:0] bufSize = 22'h2, rxThresh0 = 22'h1, rxThresh1 = 22'h0;
  logic [21:0] txThresh0 = 22'h1, txThresh1 = 22'h0;
  logic [15:0] txRspData, memWrData;
  logic memWrValid, txReqValid, rxOverrun, txUnderrun, txFrameSyncOut;
  logic txFrameSyncOe, txDataOut, txDataOe, lineClk, lineSync, lineData;
  logic [4:0] memWrChan, txReqChan;
  logic [27:0] memWrOffset, txReqOffset, rxWriteOffset, txReadOffset;
  logic [1:0] rxThreshHit, txThreshHit;
  int nFail = 0, numChecks = 0, rspCnt = 0;
  int n0, n1, t0, t1, nOvr, nUnd;
  logic [48:0] got [$];
  logic [48:0] want [$];
  wire txLine = txDataOe ? txDataOut : 1'bz;

  tdm_port i_tdm_port (.*, .rxClkPin(lineClk), .rxSyncPin(lineSync),
    .rxDataPin(lineData), .txClkPin(lineClk), .txFrameSyncIn(lineSync));

  tdm_framer_model i_tdm_framer_model (.lineClk, .lineSync, .lineData,
    .txLine, .fallEdge(sampleFalling), .syncLow(syncActiveLow));

  // System clock, 250 MHz
  always #2 clk = ~clk;

  // Memory agent: drains words, answers each fetch three cycles later
  always @(posedge clk) begin
    memWrReady <= !stall;
    if (memWrValid && memWrReady)
      got.push_back({memWrChan, memWrOffset, memWrData});
    n0 += rxThreshHit[0];
    n1 += rxThreshHit[1];
    t0 += txThreshHit[0];
    t1 += txThreshHit[1];
    nOvr += rxOverrun;
    nUnd += txUnderrun;
    txRspValid <= rspCnt == 1;
    txRspData <= 16'h5a3c ^ {11'h0, rspChan};
    if (txReqValid) begin
      rspCnt <= 3;
      rspChan <= txReqChan;
    end else if (rspCnt != 0)
      rspCnt <= rspCnt - 1;
  end

  // --------------------------------------------------------------
  // Compare and verdict
  // --------------------------------------------------------------
  task automatic compare(input logic [48:0] g, input logic [48:0] e);
    numChecks++;
    if (g !== e) begin
      nFail++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenario: configure under reset, eight frames, then compare
  // --------------------------------------------------------------
  task automatic run(input int ws, lsb, dly, fall, low, nch, act, cmp,
                     stl);
    logic [31:0] bits;
    logic [15:0] w;
    int n, wb, off, x0, x1, xo;
    wb = cmp ? 8 : 2 << ws;
    {off, x0, x1, xo} = '0;
    @(posedge clk);
    reset <= 1'h1;
    rxEnable <= 1'h0;
    txEnable <= 1'h0;
    wordSel <= ws[1:0];
    lsbFirst <= lsb[0];
    frameDelay <= dly[1:0];
    sampleFalling <= fall[0];
    syncActiveLow <= low[0];
    lastChan <= 5'(nch - 1);
    rxActive <= act;
    txActive <= act;
    compandOn <= cmp != 0;
    compandALaw <= cmp == 2;
    txSyncIsOutput <= cmp == 2;
    sharedMode <= ws[0];
    stall <= stl[0];
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    repeat (2) @(posedge clk);
    rxEnable <= 1'h1;
    txEnable <= 1'h1;
    repeat (4) @(posedge clk);
    got.delete();
    want.delete();
    {n0, n1, t0, t1, nOvr, nUnd} = '0;
    for (int f = 0; f < 8; f++) begin
      n = 0;
      for (int c = 0; c < nch; c++) begin
        w = cmp == 1 ? 16'hff : cmp == 2 ? 16'hd5 :
            16'h3c5a + 16'(f) * 16'h1111 + 16'(c) * 16'h0f0f;
        w = w & 16'((1 << wb) - 1);
        for (int k = 0; k < wb; k++)
          bits[n + k] = lsb ? w[k] : w[wb - 1 - k];
        // A full buffer with a stalled drain drops the later words
        if (act[c] && want.size() < (stl ? 16 : 99))
          want.push_back({5'(c), 28'(off),
                          cmp == 1 ? 16'h0 : cmp == 2 ? 16'h8 : w});
        else if (act[c])
          xo++;
        n += wb;
      end
      i_tdm_framer_model.send_frame(bits, n, dly);
      for (int c = 0; c < nch && cmp == 0; c++)
        for (int k = 0; k < wb; k++) begin
          w = (16'h5a3c ^ 16'(c)) & 16'((1 << wb) - 1);
          compare(i_tdm_framer_model.txSeen[dly + c * wb + k + 1],
                  act[c] ? (lsb ? w[k] : w[wb - 1 - k]) : 1'bz);
        end
      off = off + (cmp ? 16 : wb);
      off = off >= bufSize * 64 ? 0 : off;
      x0 += off == rxThresh0 * 64;
      x1 += off == rxThresh1 * 64;
    end
    stall <= 1'h0;
    for (int i = 0; i < 400 && got.size() < want.size(); i++)
      @(posedge clk);
    compare(got.size(), want.size());
    foreach (want[i]) compare(got[i], want[i]);
    compare(n0, x0);
    compare(n1, x1);
    compare(nOvr, xo);
    if (cmp != 2) compare(t0, x0);
    if (cmp != 2) compare(t1, x1);
    compare(rxWriteOffset, off);
    if (cmp != 2) compare(txReadOffset, off);
    if (cmp == 0) compare(nUnd, 0);
    compare(txFrameSyncOe, cmp == 2);
  endtask

  // Main sequence: word sizes, orders, delays, edges, polarities
  initial begin
    run(2, 0, 0, 0, 0, 2, 32'h1, 0, 0);
    run(3, 1, 3, 1, 1, 1, 32'h1, 0, 0);
    run(0, 0, 1, 0, 1, 4, 32'hb, 0, 1);
    run(1, 1, 2, 1, 0, 3, 32'h7, 0, 0);
    run(2, 0, 0, 0, 0, 2, 32'h3, 1, 0);
    run(2, 1, 1, 1, 0, 2, 32'h3, 2, 0);
    report_and_stop();
  end

  // Watchdog: the six scenarios need well under 120 us
  initial begin
    #200000;
    nFail++;
    report_and_stop();
  end
endmodule // tdm_port_test

`default_nettype wire

// ### verilog/tdm_fifo.v
// Small synchronous FIFO in flip-flops with valid/ready on both sides.
// Assumes DEPTH is a power of two and AW its log2.
`timescale 1ns/100ps
`default_nettype none

module tdm_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  localparam [AW:0] FULL = DEPTH[AW:0];

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  // Honest flags straight from the occupancy count
  assign inReady = (count_q != FULL);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = mem_q[rdPtr_q];

  // Storage needs no reset; only words behind count are ever read
  always @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  // Pointers wrap naturally at the power-of-two depth
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
      if (push & ~pop) count_q <= count_q + 1'b1;
      else if (pop & ~push) count_q <= count_q - 1'b1;
    end
  end
endmodule // tdm_fifo

`default_nettype wire

// ### verilog/tdm_port.v
// One time-division multiplexed serial port: receive and transmit frame
// engines, companding, shared buffer offsets and threshold events.
// Assumes link pins are asynchronous to clk and toggle at most once per
// two clk cycles; a memory agent drains received words and answers
// transmit fetches on clk.
`include "tdm_port_regs.vh"
`timescale 1ns/100ps
`default_nettype none

// Function
// - Each port instance is self-contained; up to four sit side by side.
// - Split mode: receive and transmit each use own data, clock, sync.
// - Shared mode: one clock and one sync time both directions.
// - Line rate up to 62.5 Mbps, 50 Mbps at slowest grade.
// - Channel buffer up to 32 MB in 8-byte steps.
// - A-law or mu-law companding in hardware; buffer doubles.
// - All receive buffers written at one shared write offset.
// - All transmit buffers read at one shared read offset.
// - One word size common to every channel.
// - Two receive and two transmit offset thresholds raise events.
// - Each channel individually active or inactive.
// - Word size 2, 4, 8 or 16 bits, stored at that width.
// - Transmit frame sync is an input or a device-driven output.
// - Sync and data sampled on rising or falling clock edge.
// - Frame sync active high or active low.
// - Zero to three bit delay between sync and first bit.
// - Word bit order MSB first or LSB first.
module tdm_port (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Link pins
  input wire rxClkPin,
  input wire rxSyncPin,
  input wire rxDataPin,
  input wire txClkPin,
  input wire txFrameSyncIn,
  output reg txFrameSyncOut,
  output reg txFrameSyncOe,
  output reg txDataOut,
  output reg txDataOe,
  // Configuration
  input wire rxEnable,
  input wire txEnable,
  input wire sharedMode,
  input wire txSyncIsOutput,
  input wire sampleFalling,
  input wire syncActiveLow,
  input wire [1:0] frameDelay,
  input wire lsbFirst,
  input wire [1:0] wordSel,
  input wire compandOn,
  input wire compandALaw,
  input wire [`TDM_CHAN_W-1:0] lastChan,
  input wire [`TDM_CHANS-1:0] rxActive,
  input wire [`TDM_CHANS-1:0] txActive,
  input wire [`TDM_SIZE_W-1:0] bufSize,
  input wire [`TDM_SIZE_W-1:0] rxThresh0,
  input wire [`TDM_SIZE_W-1:0] rxThresh1,
  input wire [`TDM_SIZE_W-1:0] txThresh0,
  input wire [`TDM_SIZE_W-1:0] txThresh1,
  // Received words toward memory
  output wire memWrValid,
  input wire memWrReady,
  output wire [`TDM_CHAN_W-1:0] memWrChan,
  output wire [`TDM_OFF_W-1:0] memWrOffset,
  output wire [`TDM_WORD_W-1:0] memWrData,
  // Transmit word fetch
  output reg txReqValid,
  output reg [`TDM_CHAN_W-1:0] txReqChan,
  output reg [`TDM_OFF_W-1:0] txReqOffset,
  input wire txRspValid,
  input wire [`TDM_WORD_W-1:0] txRspData,
  // Status
  output reg [`TDM_OFF_W-1:0] rxWriteOffset,
  output reg [`TDM_OFF_W-1:0] txReadOffset,
  output reg [1:0] rxThreshHit,
  output reg [1:0] txThreshHit,
  output reg rxOverrun,
  output reg txUnderrun
);

  // ----------------------------------------------------------------
  // Companding functions
  // ----------------------------------------------------------------
  function [7:0] muEnc;
    input [15:0] x;
    reg [15:0] m;
    reg [15:0] sh;
    reg [2:0] seg;
    integer i;
    begin
      m = x[15] ? (~x + 16'h0001) : x;
      if (m > `TDM_MU_CLIP) m = `TDM_MU_CLIP;
      m = m + `TDM_MU_BIAS;
      seg = 3'h0;
      for (i = 0; i < 7; i = i + 1) begin
        if (m[i+8]) seg = i[2:0] + 3'h1;
      end
      sh = m >> ({1'b0, seg} + 4'h3);
      muEnc = ~{x[15], seg, sh[3:0]};
    end
  endfunction

  function [15:0] muDec;
    input [7:0] c;
    reg [7:0] u;
    reg [15:0] t;
    begin
      u = ~c;
      t = ({9'h000, u[3:0], 3'h0} + `TDM_MU_BIAS) << u[6:4];
      muDec = u[7] ? (`TDM_MU_BIAS - t) : (t - `TDM_MU_BIAS);
    end
  endfunction

  function [7:0] aEnc;
    input [15:0] x;
    reg [15:0] m;
    reg [15:0] sh;
    reg [2:0] seg;
    integer i;
    begin
      m = x[15] ? ~x : x;
      seg = 3'h0;
      for (i = 0; i < 7; i = i + 1) begin
        if (m[i+8]) seg = i[2:0] + 3'h1;
      end
      sh = (seg == 3'h0) ? (m >> 4) : (m >> ({1'b0, seg} + 4'h3));
      aEnc = {1'b0, seg, sh[3:0]}
        ^ (x[15] ? `TDM_A_MASK_NEG : `TDM_A_MASK_POS);
    end
  endfunction

  function [15:0] aDec;
    input [7:0] c;
    reg [7:0] a;
    reg [15:0] t;
    begin
      a = c ^ `TDM_A_MASK_NEG;
      t = {8'h00, a[3:0], 4'h0};
      if (a[6:4] == 3'h0) t = t + `TDM_A_SEG0_ADD;
      else t = (t + `TDM_A_SEG_ADD) << (a[6:4] - 3'h1);
      aDec = a[7] ? t : (16'h0000 - t);
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [`TDM_PINS-1:0] pinIn;
  reg [`TDM_PINS-1:0] meta_q;
  reg [`TDM_PINS-1:0] pinS_q;
  assign pinIn = {txFrameSyncIn, txClkPin, rxDataPin, rxSyncPin, rxClkPin};

  // Two flops per pin, nothing shared between ports
  genvar g;
  generate
    for (g = 0; g < `TDM_PINS; g = g + 1) begin : gSync
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          meta_q[g] <= 1'b0;
          pinS_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= pinIn[g];
          pinS_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Line clock edges and common word geometry
  // ----------------------------------------------------------------
  reg rxClkPrev_q;
  reg txClkPrev_q;
  reg [4:0] wordBits;
  wire txClkS = sharedMode ? pinS_q[0] : pinS_q[3];
  wire rxRise = pinS_q[0] & ~rxClkPrev_q;
  wire rxFall = ~pinS_q[0] & rxClkPrev_q;
  wire txRise = txClkS & ~txClkPrev_q;
  wire txFall = ~txClkS & txClkPrev_q;
  wire rxSamp = sampleFalling ? rxFall : rxRise;
  wire txSamp = sampleFalling ? txFall : txRise;
  wire txDrive = sampleFalling ? txRise : txFall;

  // One word size for every channel of the port
  always @* begin
    case (wordSel)
      `TDM_WSEL_2: wordBits = 5'd2;
      `TDM_WSEL_4: wordBits = 5'd4;
      `TDM_WSEL_8: wordBits = 5'd8;
      default: wordBits = 5'd16;
    endcase
  end

  // Companded words are 8 bits on the line, 16 in memory
  wire [4:0] lineBits = compandOn ? 5'd8 : wordBits;
  wire [4:0] storeBits = compandOn ? 5'd16 : wordBits;
  wire [`TDM_OFF_W-1:0] bufBits = {bufSize, 6'h00};
  wire [9:0] frameLen = ({5'h00, lastChan} + 10'd1) * {5'h00, lineBits};

  // ----------------------------------------------------------------
  // Receive engine
  // ----------------------------------------------------------------
  reg rxSyncPrev_q;
  reg rxRun_q;
  reg [1:0] rxSkip_q;
  reg [3:0] rxBit_q;
  reg [4:0] rxChan_q;
  reg [15:0] rxShift_q;
  wire fifoInReady;
  wire rxSyncAct = pinS_q[1] ^ syncActiveLow;
  wire rxStart = rxEnable & rxSamp & rxSyncAct & ~rxSyncPrev_q;
  wire [1:0] rxSkipEff = rxStart ? frameDelay : rxSkip_q;
  wire [3:0] rxBitEff = rxStart ? 4'h0 : rxBit_q;
  wire [4:0] rxChanEff = rxStart ? 5'h00 : rxChan_q;
  wire rxLive = rxSamp & (rxStart | rxRun_q);
  wire rxTake = rxLive & (rxSkipEff == 2'h0);
  wire [15:0] rxShiftNext = lsbFirst ? {pinS_q[2], rxShift_q[15:1]}
    : {rxShift_q[14:0], pinS_q[2]};
  wire rxWordDone = rxTake & ({1'b0, rxBitEff} == lineBits - 5'd1);
  wire rxFrameEnd = rxWordDone & (rxChanEff == lastChan);
  // LSB-first words gather at the top and are shifted down
  wire [15:0] rxRaw = lsbFirst ? (rxShiftNext >> (5'd16 - lineBits))
    : (rxShiftNext & ~(16'hffff << lineBits));
  wire [15:0] rxStore = ~compandOn ? rxRaw
    : compandALaw ? aDec(rxRaw[7:0]) : muDec(rxRaw[7:0]);
  wire rxPush = rxWordDone & rxActive[rxChanEff];
  wire [`TDM_OFF_W-1:0] rxOffSum = rxWriteOffset + {23'h0, storeBits};
  wire [`TDM_OFF_W-1:0] rxOffNext = (rxOffSum >= bufBits)
    ? {`TDM_OFF_W{1'b0}} : rxOffSum;

  // Frame counters; a new sync edge always realigns a running frame
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rxClkPrev_q <= 1'b0;
      rxSyncPrev_q <= 1'b0;
      rxRun_q <= 1'b0;
      rxSkip_q <= 2'h0;
      rxBit_q <= 4'h0;
      rxChan_q <= 5'h00;
      rxShift_q <= 16'h0000;
      rxWriteOffset <= {`TDM_OFF_W{1'b0}};
      rxThreshHit <= 2'h0;
      rxOverrun <= 1'b0;
    end else begin
      rxClkPrev_q <= pinS_q[0];
      rxThreshHit <= 2'h0;
      rxOverrun <= rxPush & ~fifoInReady; // Line cannot be stalled
      if (rxSamp) rxSyncPrev_q <= rxSyncAct;
      if (~rxEnable) begin
        rxRun_q <= 1'b0;
      end else if (rxTake) begin
        rxShift_q <= rxShiftNext;
        rxRun_q <= ~rxFrameEnd;
        rxChan_q <= rxWordDone ? rxChanEff + 5'd1 : rxChanEff;
        rxBit_q <= rxWordDone ? 4'h0 : rxBitEff + 4'h1;
        rxSkip_q <= 2'h0;
      end else if (rxLive) begin
        rxRun_q <= 1'b1;
        rxSkip_q <= rxSkipEff - 2'h1;
        rxBit_q <= 4'h0;
        rxChan_q <= 5'h00;
      end
      if (rxFrameEnd) begin
        rxWriteOffset <= rxOffNext;
        rxThreshHit[0] <= (rxOffNext == {rxThresh0, 6'h00});
        rxThreshHit[1] <= (rxOffNext == {rxThresh1, 6'h00});
      end
    end
  end

  // Received words queue here while memory is busy
  tdm_fifo #(
    .WIDTH(`TDM_FIFO_W),
    .DEPTH(`TDM_FIFO_DEPTH),
    .AW(`TDM_FIFO_AW)
  ) uRxFifo (
    .clk(clk),
    .reset(reset),
    .inValid(rxPush),
    .inReady(fifoInReady),
    .inData({rxWriteOffset, rxChanEff, rxStore}),
    .outValid(memWrValid),
    .outReady(memWrReady),
    .outData({memWrOffset, memWrChan, memWrData})
  );

  // ----------------------------------------------------------------
  // Transmit engine
  // ----------------------------------------------------------------
  reg txSyncPrev_q;
  reg txRun_q;
  reg [1:0] txSkip_q;
  reg [3:0] txBit_q;
  reg [4:0] txChan_q;
  reg [15:0] txWord_q;
  reg [15:0] txNext_q;
  reg txNextOk_q;
  reg txPrimed_q;
  reg txBitOut_q;
  reg txOn_q;
  reg [9:0] txFcnt_q;
  wire genSync = (txFcnt_q == 10'h000);
  wire txSyncExt = (sharedMode ? pinS_q[1] : pinS_q[4]) ^ syncActiveLow;
  wire txSyncAct = txSyncIsOutput ? genSync : txSyncExt;
  wire txStart = txEnable & txSamp & txSyncAct & ~txSyncPrev_q;
  wire [1:0] txSkipEff = txStart ? frameDelay : txSkip_q;
  wire [3:0] txBitEff = txStart ? 4'h0 : txBit_q;
  wire [4:0] txChanEff = txStart ? 5'h00 : txChan_q;
  wire txLive = txSamp & (txStart | txRun_q);
  wire txTake = txLive & (txSkipEff == 2'h0);
  wire txSlotStart = txTake & (txBitEff == 4'h0);
  wire txWordDone = txTake & ({1'b0, txBitEff} == lineBits - 5'd1);
  wire txFrameEnd = txWordDone & (txChanEff == lastChan);
  wire txSlotOn = txActive[txChanEff];
  wire [15:0] txLoad = ~(txNextOk_q & txSlotOn) ? 16'h0000
    : ~compandOn ? txNext_q
    : {8'h00, compandALaw ? aEnc(txNext_q) : muEnc(txNext_q)};
  wire [15:0] txCur = txSlotStart ? txLoad : txWord_q;
  wire [3:0] txIdx = lsbFirst ? txBitEff
    : (lineBits[3:0] - 4'h1 - txBitEff);
  wire [4:0] txNextChan = (txChanEff == lastChan) ? 5'h00
    : txChanEff + 5'd1;
  wire [`TDM_OFF_W-1:0] txOffSum = txReadOffset + {23'h0, storeBits};
  wire [`TDM_OFF_W-1:0] txOffNext = (txOffSum >= bufBits)
    ? {`TDM_OFF_W{1'b0}} : txOffSum;
  wire txPrime = txEnable & ~txPrimed_q & ~txRun_q & ~txStart;

  // Slot sequencing; the next word is fetched one slot ahead
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      txClkPrev_q <= 1'b0;
      txSyncPrev_q <= 1'b0;
      txRun_q <= 1'b0;
      txSkip_q <= 2'h0;
      txBit_q <= 4'h0;
      txChan_q <= 5'h00;
      txWord_q <= 16'h0000;
      txNext_q <= 16'h0000;
      txNextOk_q <= 1'b0;
      txPrimed_q <= 1'b0;
      txBitOut_q <= 1'b0;
      txOn_q <= 1'b0;
      txFcnt_q <= 10'h000;
      txReqValid <= 1'b0;
      txReqChan <= 5'h00;
      txReqOffset <= {`TDM_OFF_W{1'b0}};
      txReadOffset <= {`TDM_OFF_W{1'b0}};
      txThreshHit <= 2'h0;
      txUnderrun <= 1'b0;
    end else begin
      txClkPrev_q <= txClkS;
      txThreshHit <= 2'h0;
      txReqValid <= 1'b0;
      txUnderrun <= txSlotStart & txSlotOn & ~txNextOk_q;
      if (txSamp) txSyncPrev_q <= txSyncAct;
      // Own frame timer when the device drives the sync
      if (~txEnable | ~txSyncIsOutput) txFcnt_q <= 10'h000;
      else if (txSamp) begin
        txFcnt_q <= (txFcnt_q == frameLen - 10'd1) ? 10'h000
          : txFcnt_q + 10'd1;
      end
      if (txSamp) txOn_q <= txTake & txSlotOn;
      if (~txEnable) begin
        txRun_q <= 1'b0;
        txPrimed_q <= 1'b0;
      end else if (txTake) begin
        txWord_q <= txCur;
        txBitOut_q <= txCur[txIdx];
        txRun_q <= ~txFrameEnd;
        txChan_q <= txWordDone ? txChanEff + 5'd1 : txChanEff;
        txBit_q <= txWordDone ? 4'h0 : txBitEff + 4'h1;
        txSkip_q <= 2'h0;
      end else if (txLive) begin
        txRun_q <= 1'b1;
        txSkip_q <= txSkipEff - 2'h1;
        txBit_q <= 4'h0;
        txChan_q <= 5'h00;
      end
      // Fetch only for active channels, all at the shared offset
      if (txPrime) begin
        txPrimed_q <= 1'b1;
        txReqValid <= txActive[0];
        txReqChan <= 5'h00;
        txReqOffset <= txReadOffset;
      end else if (txSlotStart) begin
        txReqValid <= txActive[txNextChan];
        txReqChan <= txNextChan;
        txReqOffset <= (txChanEff == lastChan) ? txOffNext
          : txReadOffset;
      end
      // A response in the consuming cycle wins over the consume
      if (txRspValid) begin
        txNext_q <= txRspData;
        txNextOk_q <= 1'b1;
      end else if (txSlotStart & txSlotOn) begin
        txNextOk_q <= 1'b0;
      end
      if (txFrameEnd) begin
        txReadOffset <= txOffNext;
        txThreshHit[0] <= (txOffNext == {txThresh0, 6'h00});
        txThreshHit[1] <= (txOffNext == {txThresh1, 6'h00});
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit pins; data and sync out change on the edge opposite to sampling
  // ----------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      txDataOut <= 1'b0;
      txDataOe <= 1'b0;
      txFrameSyncOut <= 1'b0;
      txFrameSyncOe <= 1'b0;
    end else begin
      txFrameSyncOe <= txEnable & txSyncIsOutput;
      if (~txEnable) begin
        txDataOe <= 1'b0;
      end else if (txDrive) begin
        txDataOut <= txBitOut_q;
        txDataOe <= txOn_q; // Inactive slots float
        txFrameSyncOut <= genSync ^ syncActiveLow;
      end
    end
  end

endmodule // tdm_port

`default_nettype wire

// ### verilog/tdm_port_regs.vh
// Constants for one TDM serial port: field widths, word-size codes,
// companding figures and buffer geometry.
// Assumes every user of it includes it once by bare name.
`ifndef TDM_PORT_REGS_VH
`define TDM_PORT_REGS_VH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define TDM_WORD_W 16
`define TDM_CHAN_W 5
`define TDM_CHANS 32
`define TDM_OFF_W 28
`define TDM_SIZE_W 22
`define TDM_UNIT_SHIFT 6
`define TDM_PINS 5

// ----------------------------------------------------------------
// Word size select codes
// ----------------------------------------------------------------
`define TDM_WSEL_2 2'h0
`define TDM_WSEL_4 2'h1
`define TDM_WSEL_8 2'h2
`define TDM_WSEL_16 2'h3

// ----------------------------------------------------------------
// Companding
// ----------------------------------------------------------------
`define TDM_MU_BIAS 16'h0084
`define TDM_MU_CLIP 16'h7f7b
`define TDM_A_MASK_POS 8'hd5
`define TDM_A_MASK_NEG 8'h55
`define TDM_A_SEG_ADD 16'h0108
`define TDM_A_SEG0_ADD 16'h0008

// ----------------------------------------------------------------
// Receive buffer FIFO
// ----------------------------------------------------------------
`define TDM_FIFO_W 49
`define TDM_FIFO_DEPTH 16
`define TDM_FIFO_AW 4

`endif
